//--- trt_timer_reset.v
// Timer and reset unit: reset cause logic, clock output gate, time-of-day
// counter with alarm, periodic interval timer and service timeout timer.
// Assumes a classic Wishbone master on mclk_in and a slow crystal clock pin.
`timescale 1ns/100ps
`include "trt_regs.vh"

module trt_timer_reset #(
    parameter PIT_W = 16,
    parameter STO_W = 6
) (
    input wire mclk_in,
    input wire rst_b_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    input wire crystal_reference_clock_in,
    input wire low_voltage_in,
    input wire ext_reset_b_in,
    input wire stop_mode_in,
    output reg sys_reset_b_out,
    output reg external_clock_output_out,
    output wire pit_irq_out,
    output wire alarm_irq_out,
    output wire wake_out
);

    reg [1:0] xtal_sync;
    reg xtal_prev;
    reg [1:0] lvd_sync;
    reg [1:0] ext_sync;
    reg [13:0] presc;
    reg [7:0] hold_cnt;
    reg in_reset;
    reg [3:0] cause;
    reg [`TRT_CTRL_W-1:0] ctrl;
    reg [PIT_W-1:0] pit_mod;
    reg [PIT_W-1:0] pit_cnt;
    reg pit_flag;
    reg [STO_W-1:0] sto_cfg;
    reg [STO_W-1:0] sto_cnt;
    reg sto_key_ok;
    reg [31:0] tday_sec;
    reg [31:0] tday_frac;
    reg [31:0] alm_sec;
    reg [31:0] alm_frac;
    reg alm_flag;
    reg fast_div;
    reg [31:0] next_rdata;
    reg [31:0] next_wdata;

    wire xtal_edge;
    wire tick_pit;
    wire tick_tday;
    wire tick_sto;
    wire wb_req;
    wire wr_en;
    wire pit_run;
    wire sto_run;
    wire sto_expire;
    wire pit_term;
    wire alm_hit;
    wire [31:0] frac_inc;

    // Reset constants sized to the registers that they load.
    localparam [PIT_W-1:0] PIT_RST = `TRT_PMOD_RST;
    localparam [STO_W-1:0] STO_RST = `TRT_WCFG_RST;
    localparam [31:0] HOLD_FULL = `TRT_RST_HOLD_CYC;
    localparam [7:0] HOLD_CYC = HOLD_FULL[7:0];

    // Crystal, low-voltage and external reset pins pass two flops before any logic reads them; the stop level is read directly.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            xtal_sync <= 2'h0;
            xtal_prev <= 1'b0;
            lvd_sync <= 2'h0;
            ext_sync <= 2'h3;
        end else begin
            xtal_sync <= {xtal_sync[0], crystal_reference_clock_in};
            xtal_prev <= xtal_sync[1];
            lvd_sync <= {lvd_sync[0], low_voltage_in};
            ext_sync <= {ext_sync[0], ext_reset_b_in};
        end
    end

    assign xtal_edge = xtal_sync[1] & ~xtal_prev;

    // The prescaler is cleared only at power-on so that time keeps running
    // through every other reset and every low-power state.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            presc <= 14'h0000;
        end else if (xtal_edge) begin
            presc <= presc + 14'h0001;
        end
    end

    // Taps fire on the crystal edge that completes each divide period.
    assign tick_pit = xtal_edge & (&presc[`TRT_PIT_DIV_BITS-1:0]);
    assign tick_tday = xtal_edge & (&presc[`TRT_TDAY_DIV_BITS-1:0]);
    assign tick_sto = xtal_edge & (&presc[`TRT_STO_DIV_BITS-1:0]);

    // Stop state halts the two timers only when software asked for it.
    assign pit_run = ctrl[`TRT_CTRL_PIT_EN] &
                     ~(stop_mode_in & ctrl[`TRT_CTRL_PIT_STOP]);
    assign sto_run = ctrl[`TRT_CTRL_STO_EN] &
                     ~(stop_mode_in & ctrl[`TRT_CTRL_STO_STOP]);
    assign sto_expire = sto_run & tick_sto & (sto_cnt == {STO_W{1'b0}});
    assign pit_term = pit_run & tick_pit & (pit_cnt == {PIT_W{1'b0}});

    // Any source starts a stretched system reset; the hold counter keeps it
    // asserted a minimum time even for a short timeout expiry pulse.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hold_cnt <= HOLD_CYC; // Power-on gets the same full stretch.
            in_reset <= 1'b1;
            cause <= `TRT_CAUSE_POR;
            sys_reset_b_out <= 1'b0;
        end else begin
            if (lvd_sync[1] | ~ext_sync[1] | sto_expire) begin
                hold_cnt <= HOLD_CYC;
                in_reset <= 1'b1;
                if (lvd_sync[1]) begin
                    cause <= `TRT_CAUSE_LVD;
                end else if (~ext_sync[1]) begin
                    cause <= `TRT_CAUSE_EXT;
                end else begin
                    cause <= `TRT_CAUSE_STO;
                end
            end else if (hold_cnt != 8'h00) begin
                hold_cnt <= hold_cnt - 8'h01;
            end else begin
                in_reset <= 1'b0;
            end
            sys_reset_b_out <= ~in_reset;
        end
    end

    // Clock output: gated off in reset and until the enable bit is set.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fast_div <= 1'b0;
            external_clock_output_out <= 1'b0;
        end else begin
            fast_div <= ~fast_div;
            external_clock_output_out <= ~in_reset & ctrl[`TRT_CTRL_CKO_EN] &
                (ctrl[`TRT_CTRL_CKO_SEL] ? fast_div : xtal_sync[1]);
        end
    end

    // Wishbone slave: one wait state, ack for one cycle, unmapped reads zero.
    assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign wr_en = wb_req & wb_we_in;

    // Byte lanes merge the write data into the addressed register's value.
    always @* begin
        next_wdata = next_rdata;
        if (wb_sel_in[0]) next_wdata[7:0] = wb_dat_in[7:0];
        if (wb_sel_in[1]) next_wdata[15:8] = wb_dat_in[15:8];
        if (wb_sel_in[2]) next_wdata[23:16] = wb_dat_in[23:16];
        if (wb_sel_in[3]) next_wdata[31:24] = wb_dat_in[31:24];
    end

    // Read multiplexer.
    always @* begin
        next_rdata = 32'h00000000;
        case (wb_adr_in)
            `TRT_CTRL_ADDR: next_rdata[`TRT_CTRL_W-1:0] = ctrl;
            `TRT_STAT_ADDR: next_rdata = {24'h000000, cause, 2'h0, alm_flag, pit_flag};
            `TRT_PMOD_ADDR: next_rdata[PIT_W-1:0] = pit_mod;
            `TRT_PCNT_ADDR: next_rdata[PIT_W-1:0] = pit_cnt;
            `TRT_WCFG_ADDR: next_rdata[STO_W-1:0] = sto_cfg;
            `TRT_WCNT_ADDR: next_rdata[STO_W-1:0] = sto_cnt;
            `TRT_TSEC_ADDR: next_rdata = tday_sec;
            `TRT_TFRC_ADDR: next_rdata = tday_frac;
            `TRT_ASEC_ADDR: next_rdata = alm_sec;
            `TRT_AFRC_ADDR: next_rdata = alm_frac;
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Bus answer registers.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h00000000;
        end else begin
            wb_ack_out <= wb_req;
            if (wb_req & ~wb_we_in) begin
                wb_dat_out <= next_rdata;
            end
        end
    end

    // Control and timer configuration; a system reset restores defaults,
    // so the clock output enable must be written again afterwards.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl <= `TRT_CTRL_RST;
            pit_mod <= PIT_RST;
            sto_cfg <= STO_RST;
        end else if (in_reset) begin
            ctrl <= `TRT_CTRL_RST;
            pit_mod <= PIT_RST;
            sto_cfg <= STO_RST;
        end else if (wr_en) begin
            if (wb_adr_in == `TRT_CTRL_ADDR) ctrl <= next_wdata[`TRT_CTRL_W-1:0];
            if (wb_adr_in == `TRT_PMOD_ADDR) pit_mod <= next_wdata[PIT_W-1:0];
            if (wb_adr_in == `TRT_WCFG_ADDR) sto_cfg <= next_wdata[STO_W-1:0];
        end
    end

    // Interval timer: reloads from the modulus at terminal count, or wraps
    // through all ones when free-running. Flag set wins over a clearing write.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pit_cnt <= PIT_RST;
            pit_flag <= 1'b0;
        end else if (in_reset) begin
            pit_cnt <= PIT_RST;
            pit_flag <= 1'b0;
        end else begin
            if (wr_en & (wb_adr_in == `TRT_PMOD_ADDR)) begin
                pit_cnt <= next_wdata[PIT_W-1:0];
            end else if (pit_term & ~ctrl[`TRT_CTRL_PIT_FREE]) begin
                pit_cnt <= pit_mod;
            end else if (pit_run & tick_pit) begin
                pit_cnt <= pit_cnt - {{(PIT_W-1){1'b0}}, 1'b1};
            end
            if (pit_term) begin
                pit_flag <= 1'b1;
            end else if (wr_en & (wb_adr_in == `TRT_STAT_ADDR) &
                         wb_sel_in[0] & wb_dat_in[`TRT_STAT_PIT_FLAG]) begin
                pit_flag <= 1'b0;
            end
        end
    end

    assign pit_irq_out = pit_flag & ctrl[`TRT_CTRL_PIT_IE];

    // Service timeout timer. The service sequence is key one then key two on
    // the service register; any value other than the two keys written there aborts the sequence.
    // A timer stopped in stop state holds its count, so the timeout resumes
    // where it was; only a disabled timer follows the programmed value.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sto_cnt <= STO_RST;
            sto_key_ok <= 1'b0;
        end else if (in_reset) begin
            sto_cnt <= STO_RST;
            sto_key_ok <= 1'b0;
        end else if (wr_en & (wb_adr_in == `TRT_WSVC_ADDR)) begin
            if (sto_key_ok & (wb_dat_in[15:0] == `TRT_WSVC_KEY2)) begin
                sto_cnt <= sto_cfg;
                sto_key_ok <= 1'b0;
            end else begin
                sto_key_ok <= (wb_dat_in[15:0] == `TRT_WSVC_KEY1);
            end
        end else if (~ctrl[`TRT_CTRL_STO_EN]) begin
            sto_cnt <= sto_cfg;
        end else if (sto_run & tick_sto & (sto_cnt != {STO_W{1'b0}})) begin
            sto_cnt <= sto_cnt - {{(STO_W-1){1'b0}}, 1'b1};
        end
    end

    // Time of day: fraction steps 0..255 and carries into seconds. Only the
    // power-on reset clears it; software may load a new time at any moment.
    assign frac_inc = tday_frac + 32'h00000001;
    assign alm_hit = (tday_sec == alm_sec) & (tday_frac == alm_frac);

    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tday_sec <= 32'h00000000;
            tday_frac <= 32'h00000000;
            alm_sec <= 32'hffffffff;
            alm_frac <= 32'hffffffff;
            alm_flag <= 1'b0;
        end else begin
            // A load wins only for the word it writes, so no tick is lost.
            if (wr_en & (wb_adr_in == `TRT_TFRC_ADDR)) begin
                tday_frac <= next_wdata & {23'h000000, 9'h0ff};
            end else if (tick_tday & (frac_inc[8:0] == `TRT_FRAC_STEPS)) begin
                tday_frac <= 32'h00000000;
            end else if (tick_tday) begin
                tday_frac <= frac_inc;
            end
            if (wr_en & (wb_adr_in == `TRT_TSEC_ADDR)) begin
                tday_sec <= next_wdata;
            end else if (tick_tday & (frac_inc[8:0] == `TRT_FRAC_STEPS)) begin
                tday_sec <= tday_sec + 32'h00000001;
            end
            if (wr_en & (wb_adr_in == `TRT_ASEC_ADDR)) alm_sec <= next_wdata;
            if (wr_en & (wb_adr_in == `TRT_AFRC_ADDR)) alm_frac <= next_wdata;
            if (tick_tday & alm_hit) begin
                alm_flag <= 1'b1;
            end else if (wr_en & (wb_adr_in == `TRT_STAT_ADDR) &
                         wb_sel_in[0] & wb_dat_in[`TRT_STAT_ALM_FLAG]) begin
                alm_flag <= 1'b0;
            end
        end
    end

    // Alarm request is level and ungated by power mode, so it can wake the core.
    assign alarm_irq_out = alm_flag & ctrl[`TRT_CTRL_ALM_IE];
    assign wake_out = alarm_irq_out | pit_irq_out;

endmodule // trt_timer_reset

//--- trt_regs.vh
// Constants for the timer and reset unit: register offsets, field positions,
// reset values and timing counts. Definitions only; included by trt_timer_reset.v.
// Functional notes
// - Low-voltage, external pin, power-on and timeout expiry each reset the system.
// - One cause flag per source; each reset sets its own flag and clears the others, so the most recent cause is recorded.
// - Clock output is off during reset and stays off until software enables it.
// - Time-of-day counter always runs, ticking at crystal clock divided by 128.
// - Two 32-bit registers hold seconds and 1/256 fractions, fraction carries into seconds.
// - Time-of-day counter keeps counting in every low-power state, never gated.
// - Alarm raises a request that can wake the processor from any low-power state.
// - Interval timer ticks at crystal clock divided by 4, reloads or runs free.
// - Timeout timer ticks at crystal divided by 16384, 6-bit count, expiry resets.
// - Each complete service sequence reloads the timeout count from the programmed value.
// - In stop state both timers keep running unless software chose to stop them.
`ifndef TRT_REGS_VH
`define TRT_REGS_VH

// Register byte offsets.
`define TRT_CTRL_ADDR 8'h00
`define TRT_STAT_ADDR 8'h04
`define TRT_PMOD_ADDR 8'h08
`define TRT_PCNT_ADDR 8'h0c
`define TRT_WCFG_ADDR 8'h10
`define TRT_WSVC_ADDR 8'h14
`define TRT_WCNT_ADDR 8'h18
`define TRT_TSEC_ADDR 8'h1c
`define TRT_TFRC_ADDR 8'h20
`define TRT_ASEC_ADDR 8'h24
`define TRT_AFRC_ADDR 8'h28

// Control register fields.
`define TRT_CTRL_PIT_EN 0
`define TRT_CTRL_PIT_FREE 1
`define TRT_CTRL_PIT_IE 2
`define TRT_CTRL_PIT_STOP 3
`define TRT_CTRL_STO_EN 4
`define TRT_CTRL_STO_STOP 5
`define TRT_CTRL_CKO_EN 6
`define TRT_CTRL_CKO_SEL 7
`define TRT_CTRL_ALM_IE 8
`define TRT_CTRL_W 9
`define TRT_CTRL_RST 9'h000

// Status register fields.
`define TRT_STAT_PIT_FLAG 0
`define TRT_STAT_ALM_FLAG 1
`define TRT_STAT_CAUSE_LSB 4
`define TRT_CAUSE_LVD 4'h1
`define TRT_CAUSE_EXT 4'h2
`define TRT_CAUSE_POR 4'h4
`define TRT_CAUSE_STO 4'h8

// Reset values of the counters and service keys.
`define TRT_PMOD_RST 16'hffff
`define TRT_WCFG_RST 6'h3f
`define TRT_WSVC_KEY1 16'h5555
`define TRT_WSVC_KEY2 16'haaaa
`define TRT_FRAC_STEPS 9'h100

// Prescaler tap widths: divide by 4, 128 and 16384.
`define TRT_PIT_DIV_BITS 2
`define TRT_TDAY_DIV_BITS 7
`define TRT_STO_DIV_BITS 14

// Reset hold time and its cycle count at the system clock.
`define TRT_CLK_MHZ 20
`define TRT_RST_HOLD_NS 1000
`define TRT_RST_HOLD_CYC ((`TRT_RST_HOLD_NS * `TRT_CLK_MHZ + 999) / 1000)

`endif

//--- trt_timer_reset_sva.sv
// Checker for the timer and reset unit: port relations of reset, bus and requests.
// Assumes it is bound to trt_timer_reset and sees only that module's ports.
`timescale 1ns/100ps
module trt_timer_reset_sva (
    input wire mclk_in,
    input wire rst_b_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire wb_ack_out,
    input wire low_voltage_in,
    input wire ext_reset_b_in,
    input wire sys_reset_b_out,
    input wire external_clock_output_out,
    input wire pit_irq_out,
    input wire alarm_irq_out,
    input wire wake_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    reg [7:0] low_cnt;
    // Counts cycles of held system reset; saturates so a long hold cannot wrap.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) low_cnt <= 8'h00;
        else if (sys_reset_b_out) low_cnt <= 8'h00;
        else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
    end
    ack_answer_a: assert property ((wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
        else $error("bus request not answered next cycle");
    ack_single_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("acknowledge longer than one cycle");
    lvd_reset_a: assert property (low_voltage_in [*6] |-> !sys_reset_b_out)
        else $error("low voltage did not reset the system");
    ext_reset_a: assert property (!ext_reset_b_in [*6] |-> !sys_reset_b_out)
        else $error("external pin did not reset the system");
    reset_stretch_a: assert property ($rose(sys_reset_b_out) |-> low_cnt >= 8'h14)
        else $error("system reset shorter than 20 cycles");
    external_clock_output_gate_a: assert property (!sys_reset_b_out [*3] |-> !external_clock_output_out)
        else $error("clock output active during reset");
    wake_or_a: assert property (wake_out == (pit_irq_out || alarm_irq_out))
        else $error("wake request differs from the two requests");
    alarm_hold_a: assert property ($fell(alarm_irq_out) |->
        $past(wb_stb_in && wb_we_in) || !sys_reset_b_out)
        else $error("alarm request dropped without a write");
    pit_hold_a: assert property ($fell(pit_irq_out) |->
        $past(wb_stb_in && wb_we_in) || !sys_reset_b_out)
        else $error("interval request dropped without a write");
endmodule // trt_timer_reset_sva

bind trt_timer_reset trt_timer_reset_sva u_trt_timer_reset_sva (.mclk_in(mclk_in),
    .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_ack_out(wb_ack_out), .low_voltage_in(low_voltage_in),
    .ext_reset_b_in(ext_reset_b_in), .sys_reset_b_out(sys_reset_b_out),
    .external_clock_output_out(external_clock_output_out), .pit_irq_out(pit_irq_out),
    .alarm_irq_out(alarm_irq_out), .wake_out(wake_out));

//--- tb_timer_reset_unit.sv
// Self-checking bench for the timer and reset unit.
// Drives Wishbone, crystal, reset sources and stop level itself; no partner model.
`timescale 1ns/100ps
`include "trt_regs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_timer_reset_unit;
    reg mclk_in, rst_b_in, cyc, stb, we, xtal, lvd, ext_b, stop, b;
    reg [7:0] adr;
    reg [3:0] sel;
    reg [31:0] wdat, q, r;
    wire [31:0] rdat;
    wire ack, srst_b, cko, pirq, airq, wake;
    int miscompares = 0;
    int tests_run = 0;
    int n;
    trt_timer_reset u_trt_timer_reset (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .crystal_reference_clock_in(xtal), .low_voltage_in(lvd), .ext_reset_b_in(ext_b),
        .stop_mode_in(stop), .sys_reset_b_out(srst_b), .external_clock_output_out(cko),
        .pit_irq_out(pirq), .alarm_irq_out(airq), .wake_out(wake));
    // Clock of 50 ns period.
    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    // Crystal stand-in toggles every clock so the long taps finish within the run.
    always @(posedge mclk_in) xtal <= ~xtal;
    // Watchdog: the timeout expiry comes near cycle 33k, so 50k leaves margin.
    initial begin
        repeat (50000) @(posedge mclk_in);
        miscompares++;
        report_and_stop();
    end
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Status word with both flags clear and the given cause.
    function [31:0] stat_exp(input [3:0] c);
        stat_exp = {24'h0, c, 4'h0};
    endfunction
    // One classic bus cycle; read data lands in q.
    task xfer(input [7:0] a, input w, input [31:0] d);
        int k;
        k = 0;
        @(posedge mclk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk_in);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = rdat;
        if (k >= 20) miscompares++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task chk_rd(input [7:0] a, input [31:0] e, input string nm);
        xfer(a, 1'b0, 32'h0);
        `CHK(nm, e, q)
    endtask
    task wait_up();
        n = 0;
        while (srst_b !== 1'b1 && n < 300) begin
            @(posedge mclk_in);
            n++;
        end
        if (n >= 300) miscompares++;
    endtask
    // Holds one reset source for 8 cycles, then waits out the stretch.
    task pulse(input l);
        if (l) lvd <= 1'b1;
        else ext_b <= 1'b0;
        repeat (8) @(posedge mclk_in);
        lvd <= 1'b0;
        ext_b <= 1'b1;
        wait_up();
    endtask
    task report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Main sequence.
    initial begin
        {rst_b_in, cyc, stb, we, xtal, lvd, stop, adr, wdat} = '0;
        ext_b = 1'b1;
        sel = 4'hf;
        repeat (4) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        wait_up();
        chk_rd(`TRT_STAT_ADDR, stat_exp(`TRT_CAUSE_POR), "status");
        chk_rd(`TRT_CTRL_ADDR, 32'h0, "ctrl");
        chk_rd(`TRT_PMOD_ADDR, 32'hffff, "modulus");
        chk_rd(`TRT_WCFG_ADDR, 32'h3f, "timeout cfg");
        chk_rd(8'h40, 32'h0, "unmapped");
        `CHK("clock out", 1'b0, cko)
        r = 32'h1;
        repeat (6) begin
            r = lfsr(r);
            xfer(`TRT_CTRL_ADDR, 1'b1, r & 32'h1ef);
            chk_rd(`TRT_CTRL_ADDR, r & 32'h1ef, "ctrl");
            xfer(`TRT_ASEC_ADDR, 1'b1, r);
            chk_rd(`TRT_ASEC_ADDR, r, "alarm sec");
        end
        // Byte lanes: only the low byte of the control word may change.
        sel <= 4'h1;
        xfer(`TRT_CTRL_ADDR, 1'b1, 32'h2ef);
        sel <= 4'hf;
        chk_rd(`TRT_CTRL_ADDR, (r & 32'h100) | 32'hef, "ctrl lanes");
        // Clock output at half rate, then cut by an external reset.
        xfer(`TRT_CTRL_ADDR, 1'b1, 32'hc0);
        repeat (4) @(posedge mclk_in);
        b = cko;
        @(posedge mclk_in);
        `CHK("clock toggle", ~b, cko)
        pulse(1'b0);
        `CHK("clock out", 1'b0, cko)
        chk_rd(`TRT_STAT_ADDR, stat_exp(`TRT_CAUSE_EXT), "status");
        chk_rd(`TRT_CTRL_ADDR, 32'h0, "ctrl");
        // Software turns the crystal clock output back on after the reset.
        xfer(`TRT_CTRL_ADDR, 1'b1, 32'h40);
        n = 0;
        while (cko !== 1'b1 && n < 10) begin
            @(posedge mclk_in);
            n++;
        end
        `CHK("clock back", 1'b1, cko)
        pulse(1'b1);
        chk_rd(`TRT_STAT_ADDR, stat_exp(`TRT_CAUSE_LVD), "status");
        // Fraction rollover while the stop level is high.
        stop <= 1'b1;
        xfer(`TRT_TSEC_ADDR, 1'b1, 32'h5);
        xfer(`TRT_TFRC_ADDR, 1'b1, 32'hff);
        n = 0;
        do begin
            xfer(`TRT_TFRC_ADDR, 1'b0, 32'h0);
            n++;
        end while (q == 32'hff && n < 200);
        stop <= 1'b0;
        `CHK("fraction", 32'h0, q)
        chk_rd(`TRT_TSEC_ADDR, 32'h6, "seconds");
        // Alarm two fraction steps ahead.
        xfer(`TRT_ASEC_ADDR, 1'b1, 32'h6);
        xfer(`TRT_AFRC_ADDR, 1'b1, 32'h2);
        xfer(`TRT_CTRL_ADDR, 1'b1, 32'h100);
        n = 0;
        while (airq !== 1'b1 && n < 1000) begin
            @(posedge mclk_in);
            n++;
        end
        `CHK("wake", 1'b1, wake)
        chk_rd(`TRT_STAT_ADDR, stat_exp(`TRT_CAUSE_LVD) | 32'h2, "status");
        xfer(`TRT_STAT_ADDR, 1'b1, 32'h2);
        `CHK("alarm req", 1'b0, airq)
        // Interval timer with modulus 3; a period is 4 ticks of 8 cycles.
        xfer(`TRT_PMOD_ADDR, 1'b1, 32'h3);
        xfer(`TRT_CTRL_ADDR, 1'b1, 32'h5);
        for (int i = 0; i < 2; i++) begin
            n = 0;
            while (pirq !== 1'b1 && n < 100) begin
                @(posedge mclk_in);
                n++;
            end
            if (i == 1) `CHK("pit period ok", 1'b1, n >= 20 && n <= 40)
            xfer(`TRT_STAT_ADDR, 1'b1, 32'h1);
        end
        // Free-running: terminal count flags and wraps to all ones on the same tick.
        xfer(`TRT_CTRL_ADDR, 1'b1, 32'h7);
        n = 0;
        while (pirq !== 1'b1 && n < 100) begin
            @(posedge mclk_in);
            n++;
        end
        chk_rd(`TRT_PCNT_ADDR, 32'hffff, "free wrap");
        xfer(`TRT_STAT_ADDR, 1'b1, 32'h1);
        // Stop state halts the interval timer only while its stop bit is set.
        stop <= 1'b1;
        xfer(`TRT_CTRL_ADDR, 1'b1, 32'h9);
        xfer(`TRT_PMOD_ADDR, 1'b1, 32'h100);
        repeat (40) @(posedge mclk_in);
        chk_rd(`TRT_PCNT_ADDR, 32'h100, "halted count");
        xfer(`TRT_CTRL_ADDR, 1'b1, 32'h1);
        repeat (40) @(posedge mclk_in);
        stop <= 1'b0;
        xfer(`TRT_PCNT_ADDR, 1'b0, 32'h0);
        `CHK("running in stop", 1'b1, q < 32'h100)
        // Service reload, then expiry from a zero count.
        xfer(`TRT_WCFG_ADDR, 1'b1, 32'h5);
        xfer(`TRT_CTRL_ADDR, 1'b1, 32'h10);
        xfer(`TRT_WSVC_ADDR, 1'b1, 32'h5555);
        xfer(`TRT_WSVC_ADDR, 1'b1, 32'haaaa);
        chk_rd(`TRT_WCNT_ADDR, 32'h5, "timeout count");
        xfer(`TRT_WCFG_ADDR, 1'b1, 32'h0);
        xfer(`TRT_WSVC_ADDR, 1'b1, 32'h5555);
        xfer(`TRT_WSVC_ADDR, 1'b1, 32'haaaa);
        n = 0;
        while (srst_b !== 1'b0 && n < 40000) begin
            @(posedge mclk_in);
            n++;
        end
        wait_up();
        chk_rd(`TRT_STAT_ADDR, stat_exp(`TRT_CAUSE_STO), "status");
        report_and_stop();
    end
endmodule // tb_timer_reset_unit
